// ==== design/cdio_edge.sv ====
module cdio_edge (
  input wire logic clk,
  input wire logic sys_rst,
  cdio_io_if.cond io
);
  logic trig_q;
  logic clear_q;

  // previous levels for edge detection
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      trig_q <= 1'b0;
      clear_q <= 1'b0;
    end
    else
    begin
      trig_q <= io.trig;
      clear_q <= io.clear;
    end
  end

  // only rising edges count, a steady high starts nothing
  assign io.trig_rise = io.trig & ~trig_q;
  assign io.clear_rise = io.clear & ~clear_q;
endmodule : cdio_edge

// ==== design/cdio_io_if.sv ====
interface cdio_io_if;
  logic ext_en;
  logic [3:0] sel;
  logic teach;
  logic trig;
  logic clear;
  logic trig_rise;
  logic clear_rise;

  modport src (output ext_en, sel, teach, trig, clear, input trig_rise, clear_rise);
  modport cond (input ext_en, sel, teach, trig, clear, output trig_rise, clear_rise);
endinterface : cdio_io_if

// ==== design/cdio_pkg.sv ====
package cdio_pkg;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_TAUGHT = 8'h0C;

  // control register fields
  localparam int CTRL_DIO_SRC_BIT = 0;
  localparam int CTRL_ERR_SET_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // result register fields, written by the image engine to close a cycle
  localparam int RES_DECODED_BIT = 0;
  localparam int RES_MATCH_BIT = 1;
  localparam int RES_UNREAD_BIT = 2;
  localparam int RES_DONE_BIT = 3;

  // status register fields
  localparam int ST_PROG_LSB = 0;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_SAVE_BIT = 5;
  localparam int ST_KEYLOCK_BIT = 6;
  localparam int ST_HEALTHY_BIT = 7;
  localparam int ST_READY_BIT = 8;
  localparam int ST_TAUGHT_BIT = 9;
  localparam int ST_RESULT_LSB = 10;

  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int PROG_CHANGE_MS = 150;
  localparam int PROG_CHANGE_CYC = PROG_CHANGE_MS * (CLK_HZ / 1000);
  localparam int SAVE_TRIG_MS = 5;
  localparam int SAVE_TRIG_CYC = SAVE_TRIG_MS * (CLK_HZ / 1000);

  // operating states
  typedef enum logic [3:0] {
    ST_STARTUP = 4'b0001,
    ST_RUN = 4'b0010,
    ST_CHANGE = 4'b0100,
    ST_TEACH = 4'b1000
  } cdio_state_e;

endpackage : cdio_pkg

// ==== design/cdio_top.sv ====
// Operation
// - discrete lines honoured only when selected source
// - select and teach need enable high
// - enable high locks out keypad
// - select lines form binary program number
// - teach high turns bit 1 into save
// - teach high means program save mode
// - each trigger rising edge in run, with no error pending, starts one cycle
// - healthy low while error pending
// - in run taught shows program saved
// - taught low while saving, high acknowledges
// - ready low in startup or stop
// - decoded flag when code read
// - match flag when code equals taught
// - unreadable flag when code unreadable
// - program zero keeps previous program
// - program change drops taught and ready
//
// Register access over APB and the register addresses were chosen for this implementation.
module cdio_top #(
  parameter int CHANGE_CYC = cdio_pkg::PROG_CHANGE_CYC,
  parameter int SAVE_CYC = cdio_pkg::SAVE_TRIG_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic external_control_enable,
  input wire logic prog_sel_bit_0,
  input wire logic prog_sel_bit_1,
  input wire logic prog_sel_bit_2,
  input wire logic prog_sel_bit_3,
  input wire logic teach_mode,
  input wire logic capture_trigger,
  input wire logic error_clear,
  input wire logic keypad_active,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic healthy,
  output logic program_taught,
  output logic run_ready,
  output logic result_decoded,
  output logic result_match,
  output logic result_unreadable,
  output logic capture_start,
  output logic save_start,
  output logic keypad_locked
);

  // counters are 24 bits wide, so longer delays cannot be served
  if (CHANGE_CYC < 1 || CHANGE_CYC > 32'h00FF_FFFF
    || SAVE_CYC < 1 || SAVE_CYC > 32'h00FF_FFFF)
  begin : g_bad_cycles
    $error("cdio_top: cycle counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  cdio_io_if io ();
  assign io.sel = {prog_sel_bit_3, prog_sel_bit_2, prog_sel_bit_1, prog_sel_bit_0};
  assign io.ext_en = external_control_enable;
  assign io.teach = teach_mode;
  assign io.trig = capture_trigger;
  assign io.clear = error_clear;

  cdio_edge u_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .io(io)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_q;
  logic [14:0] taught_q;
  logic [3:0] prog_q;
  logic err_q;
  logic busy_q;
  logic [23:0] cnt_q;
  logic [23:0] trig_cnt_q;
  cdio_pkg::cdio_state_e state_q;

  // source gate; without it every discrete line is dead
  logic dio_on;
  logic ctl_on;
  logic [3:0] req_prog;
  logic save_cmd;
  logic trig_ev;
  logic clear_ev;
  assign dio_on = ctrl_q[cdio_pkg::CTRL_DIO_SRC_BIT];
  assign ctl_on = dio_on & io.ext_en;
  // bit 1 becomes the save command while teaching
  assign req_prog = {io.sel[3:2], io.sel[1] & ~io.teach, io.sel[0]};
  assign save_cmd = ctl_on & io.teach & io.sel[1];
  assign trig_ev = dio_on & io.trig_rise;
  assign clear_ev = ctl_on & io.clear_rise & (io.sel == 4'h0) & ~io.teach;

  function automatic logic is_taught(input logic [14:0] t, input logic [3:0] p);
    is_taught = (p == 4'h0) ? 1'b0 : t[p - 4'h1];
  endfunction : is_taught

  ////////////////////////////////////////////////////////////////////////////
  logic wr_en;
  logic rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  // control register; software picks the source and can raise an error
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_q <= cdio_pkg::CTRL_RESET;
    else if (wr_en && paddr == cdio_pkg::REG_CTRL)
      ctrl_q <= {30'h0000_0000, 1'b0, pwdata[cdio_pkg::CTRL_DIO_SRC_BIT]};
  end

  // error flag: set wins over clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      err_q <= 1'b0;
    else if (wr_en && paddr == cdio_pkg::REG_CTRL && pwdata[cdio_pkg::CTRL_ERR_SET_BIT])
      err_q <= 1'b1;
    else if (trig_ev && state_q != cdio_pkg::ST_RUN && state_q != cdio_pkg::ST_TEACH)
      err_q <= 1'b1;
    else if (clear_ev)
      err_q <= 1'b0;
  end

  // state machine for startup, program change and teaching
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= cdio_pkg::ST_STARTUP;
      cnt_q <= 24'h00_0000;
      prog_q <= 4'h1;
    end
    else
    begin
      case (state_q)
        cdio_pkg::ST_STARTUP:
        begin
          cnt_q <= cnt_q + 24'h00_0001;
          if (cnt_q >= 24'(CHANGE_CYC - 1))
          begin
            state_q <= cdio_pkg::ST_RUN;
            cnt_q <= 24'h00_0000;
          end
        end
        cdio_pkg::ST_RUN:
        begin
          if (ctl_on && io.teach)
            state_q <= cdio_pkg::ST_TEACH;
          else if (ctl_on && req_prog != 4'h0 && req_prog != prog_q)
          begin
            prog_q <= req_prog;
            state_q <= cdio_pkg::ST_CHANGE;
            cnt_q <= 24'h00_0000;
          end
        end
        cdio_pkg::ST_CHANGE:
        begin
          cnt_q <= cnt_q + 24'h00_0001;
          if (cnt_q >= 24'(CHANGE_CYC - 1))
            state_q <= cdio_pkg::ST_RUN;
        end
        cdio_pkg::ST_TEACH:
        begin
          // leaving teach passes through the change delay
          if (!(ctl_on && io.teach))
          begin
            state_q <= cdio_pkg::ST_CHANGE;
            cnt_q <= 24'h00_0000;
          end
        end
        default:
          state_q <= cdio_pkg::ST_STARTUP;
      endcase
    end
  end

  // trigger high time while saving; short pulses save nothing
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      trig_cnt_q <= 24'h00_0000;
    else if (!io.trig || state_q != cdio_pkg::ST_TEACH)
      trig_cnt_q <= 24'h00_0000;
    else if (trig_cnt_q != 24'hFF_FFFF)
      trig_cnt_q <= trig_cnt_q + 24'h00_0001;
  end

  // save request to the image engine after the trigger has been held
  logic save_go;
  assign save_go = save_cmd && state_q == cdio_pkg::ST_TEACH && io.trig
    && trig_cnt_q == 24'(SAVE_CYC - 1);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      save_start <= 1'b0;
    else
      save_start <= save_go;
  end

  // taught table; engine confirms a save by writing the taught register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      taught_q <= 15'h0000;
    else if (wr_en && paddr == cdio_pkg::REG_TAUGHT)
      taught_q <= pwdata[14:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture requests; one pulse per edge, only in run
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      capture_start <= 1'b0;
    else
      capture_start <= trig_ev && state_q == cdio_pkg::ST_RUN && !err_q;
  end

  // busy from start until engine reports done
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      busy_q <= 1'b0;
    else if (capture_start)
      busy_q <= 1'b1;
    else if (wr_en && paddr == cdio_pkg::REG_RESULT && pwdata[cdio_pkg::RES_DONE_BIT])
      busy_q <= 1'b0;
  end

  // result flags cleared on a new start, held until the next start
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      result_decoded <= 1'b0;
      result_match <= 1'b0;
      result_unreadable <= 1'b0;
    end
    else if (capture_start)
    begin
      result_decoded <= 1'b0;
      result_match <= 1'b0;
      result_unreadable <= 1'b0;
    end
    else if (busy_q && wr_en && paddr == cdio_pkg::REG_RESULT
      && pwdata[cdio_pkg::RES_DONE_BIT])
    begin
      // unreadable outranks decoded so both never show
      result_unreadable <= pwdata[cdio_pkg::RES_UNREAD_BIT];
      result_decoded <= pwdata[cdio_pkg::RES_DECODED_BIT]
        & ~pwdata[cdio_pkg::RES_UNREAD_BIT];
      result_match <= pwdata[cdio_pkg::RES_MATCH_BIT]
        & ~pwdata[cdio_pkg::RES_UNREAD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs, all registered
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      healthy <= 1'b0;
      run_ready <= 1'b0;
      program_taught <= 1'b0;
      keypad_locked <= 1'b0;
    end
    else
    begin
      healthy <= ~err_q && state_q != cdio_pkg::ST_STARTUP;
      run_ready <= state_q == cdio_pkg::ST_RUN && !err_q;
      if (state_q == cdio_pkg::ST_TEACH)
        program_taught <= is_taught(taught_q, prog_q) & ~save_cmd;
      else
        program_taught <= state_q == cdio_pkg::ST_RUN && is_taught(taught_q, prog_q);
      keypad_locked <= ctl_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] status_w;
  assign status_w = {19'h0_0000, result_unreadable, result_match, result_decoded,
    program_taught, run_ready, healthy, ctl_on, state_q == cdio_pkg::ST_TEACH,
    busy_q, prog_q};

  // read data latched in setup so it is ready in access phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= 1'b0;
      if (paddr == cdio_pkg::REG_CTRL)
        prdata <= ctrl_q;
      else if (paddr == cdio_pkg::REG_STATUS)
        prdata <= status_w;
      else if (paddr == cdio_pkg::REG_RESULT)
        prdata <= {28'h000_0000, ~busy_q, result_unreadable, result_match, result_decoded};
      else if (paddr == cdio_pkg::REG_TAUGHT)
        prdata <= {17'h0_0000, taught_q};
      else
      begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b1; // unmapped address
      end
    end
  end

  // zero wait states
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pready <= 1'b0;
    else
      pready <= psel & ~penable;
  end

  logic unused_ok;
  assign unused_ok = rd_en | keypad_active;

endmodule : cdio_top

// ==== verif/cdio_assertions.sv ====
module cdio_chk #(
  parameter int CHANGE_CYC = cdio_pkg::PROG_CHANGE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic external_control_enable,
  input wire logic prog_sel_bit_1,
  input wire logic teach_mode,
  input wire logic capture_trigger,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic healthy,
  input wire logic run_ready,
  input wire logic result_decoded,
  input wire logic result_unreadable,
  input wire logic capture_start,
  input wire logic save_start,
  input wire logic keypad_locked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [23:0] low_q;
  //////////////////////////////////////////////////////////////////////////////
  // length of the current ready-low stretch, saturating so it never wraps
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      low_q <= 24'h00_0000;
    else if (run_ready)
      low_q <= 24'h00_0000;
    else if (low_q != 24'hFF_FFFF)
      low_q <= low_q + 24'h00_0001;
  end
  //////////////////////////////////////////////////////////////////////////////
  chk_start_single: assert property (capture_start |=> !capture_start)
    else $error("capture start longer than one cycle");
  chk_start_cause: assert property (capture_start |-> $past(capture_trigger))
    else $error("capture start without trigger");
  chk_result_excl: assert property (!(result_decoded && result_unreadable))
    else $error("decoded and unreadable together");
  chk_lock_enable: assert property (keypad_locked |-> $past(external_control_enable))
    else $error("keypad locked without enable");
  chk_save_gate: assert property (save_start |-> $past(teach_mode && prog_sel_bit_1
    && external_control_enable))
    else $error("save start without teach and save line");
  chk_result_hold: assert property ($changed({result_decoded, result_unreadable})
    |-> $past(psel && penable && pwrite) || $past(capture_start) || capture_start)
    else $error("result flags changed without cause");
  chk_err_health: assert property (psel && penable && pwrite && pready
    && paddr == cdio_pkg::REG_CTRL && pwdata[1] |=> ##[0:2] !healthy)
    else $error("healthy stayed high on error");
  // error recovery is short and unhealthy; only a healthy ready-low stretch is a change
  chk_ready_count: assert property ($rose(run_ready) && $past(healthy)
    |-> low_q >= CHANGE_CYC - 2)
    else $error("ready rose too early");
endmodule : cdio_chk

bind cdio_top cdio_chk #(.CHANGE_CYC(CHANGE_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .external_control_enable(external_control_enable), .prog_sel_bit_1(prog_sel_bit_1),
  .teach_mode(teach_mode), .capture_trigger(capture_trigger), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .healthy(healthy), .run_ready(run_ready), .result_decoded(result_decoded),
  .result_unreadable(result_unreadable), .capture_start(capture_start),
  .save_start(save_start), .keypad_locked(keypad_locked));

// ==== verif/cdio_plc.sv ====
module cdio_plc (
  input wire logic clk,
  output logic en,
  output logic [3:0] sel,
  output logic teach,
  output logic trig,
  output logic clear
);
  timeunit 1ns;
  timeprecision 1ns;
  // controller lines idle low from time zero
  initial
  begin
    {en, sel, teach, trig, clear} = 8'h00;
  end
  task automatic drive(input logic e, input logic [3:0] s, input logic t);
    @(posedge clk);
    en <= e;
    sel <= s;
    teach <= t;
  endtask : drive
  // trigger held for hold cycles; a save needs at least the save hold
  task automatic pulse(input int hold);
    @(posedge clk);
    trig <= 1'b1;
    repeat (hold) @(posedge clk);
    trig <= 1'b0;
  endtask : pulse
  // lines to zero with enable kept high, then the clear pulse
  task automatic clear_err();
    drive(1'b1, 4'h0, 1'b0);
    @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
  endtask : clear_err
endmodule : cdio_plc

// ==== verif/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic keypad = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, en, teach, trig, clear;
  logic [3:0] sel;
  logic healthy, program_taught, run_ready, result_decoded, result_match;
  logic result_unreadable, capture_start, save_start, keypad_locked;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int starts = 0;
  int saves = 0;
  int progs[5] = '{2, 4, 8, 1, 11};
  always #50 clk = ~clk;
  cdio_plc u_plc (.clk(clk), .en(en), .sel(sel), .teach(teach), .trig(trig), .clear(clear));
  cdio_top #(.CHANGE_CYC(10), .SAVE_CYC(4)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .external_control_enable(en), .prog_sel_bit_0(sel[0]), .prog_sel_bit_1(sel[1]),
    .prog_sel_bit_2(sel[2]), .prog_sel_bit_3(sel[3]), .teach_mode(teach),
    .capture_trigger(trig), .error_clear(clear), .keypad_active(keypad), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .healthy(healthy), .program_taught(program_taught),
    .run_ready(run_ready), .result_decoded(result_decoded), .result_match(result_match),
    .result_unreadable(result_unreadable), .capture_start(capture_start),
    .save_start(save_start), .keypad_locked(keypad_locked));
  //////////////////////////////////////////////////////////////////////////////
  // pulse counters and the hang guard
  always @(posedge clk)
  begin
    starts += (capture_start === 1'b1);
    saves += (save_start === 1'b1);
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic ck(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : ck
  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // checks sit on the falling edge, well clear of the bench's own drives
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic wait_rdy();
    for (int n = 0; n < 100 && run_ready !== 1'b1; n++)
      w(1);
  endtask : wait_rdy
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    w(2);
    ck("ready startup", 0, 32'(run_ready));
    wait_rdy();
    ck("ready run", 1, 32'(run_ready));
    ck("healthy", 1, 32'(healthy));
    apb(1'b0, 8'h10, 32'h0);
    ck("unmapped err", 1, 32'(err));
    u_plc.drive(1'b1, 4'h5, 1'b0);
    u_plc.pulse(2);
    w(4);
    ck("source off", 0, 32'(starts));
    ck("ready source off", 1, 32'(run_ready));
    u_plc.drive(1'b0, 4'h5, 1'b0);
    apb(1'b1, cdio_pkg::REG_CTRL, 32'h1);
    apb(1'b1, cdio_pkg::REG_TAUGHT, 32'h7FFF);
    w(4);
    apb(1'b0, cdio_pkg::REG_STATUS, 32'h0);
    ck("prog enable off", 1, 32'(rd[3:0]));
    u_plc.drive(1'b1, 4'h0, 1'b0);
    w(4);
    apb(1'b0, cdio_pkg::REG_STATUS, 32'h0);
    ck("prog zero", 1, 32'(rd[3:0]));
    ck("keypad lock", 1, 32'(keypad_locked));
    // a keypad in use must not release the lock
    @(posedge clk);
    keypad <= 1'b1;
    w(2);
    ck("keypad lock held", 1, 32'(keypad_locked));
    $display("test setup done");
    foreach (progs[i])
    begin
      u_plc.drive(1'b1, 4'(progs[i]), 1'b0);
      w(3);
      ck("change ready", 0, 32'({run_ready, program_taught}));
      wait_rdy();
      ck("change back", 3, 32'({run_ready, program_taught}));
      apb(1'b0, cdio_pkg::REG_STATUS, 32'h0);
      ck("prog number", progs[i], 32'(rd[3:0]));
    end
    apb(1'b1, cdio_pkg::REG_TAUGHT, 32'h7BFF);
    w(2);
    ck("taught unsaved", 0, 32'(program_taught));
    $display("test program done");
    u_plc.pulse(2);
    apb(1'b1, cdio_pkg::REG_RESULT, 32'hB);
    w(2);
    ck("decoded match", 3, 32'({result_match, result_decoded}));
    u_plc.pulse(8);
    apb(1'b1, cdio_pkg::REG_RESULT, 32'hD);
    w(6);
    ck("unreadable", 2, 32'({result_unreadable, result_decoded}));
    ck("starts", 2, 32'(starts));
    $display("test trigger done");
    u_plc.drive(1'b1, 4'h0, 1'b1);
    w(4);
    apb(1'b0, cdio_pkg::REG_STATUS, 32'h0);
    ck("teach mode", 1, 32'(rd[cdio_pkg::ST_SAVE_BIT]));
    ck("teach outs", 0, 32'({run_ready, program_taught}));
    u_plc.drive(1'b1, 4'h2, 1'b1);
    u_plc.pulse(6);
    w(3);
    ck("save pulse", 1, 32'(saves));
    // engine confirms the save; with the save line down the ack shows
    apb(1'b1, cdio_pkg::REG_TAUGHT, 32'h7FFF);
    u_plc.drive(1'b1, 4'h0, 1'b1);
    w(3);
    ck("teach ack", 1, 32'({run_ready, program_taught}));
    u_plc.drive(1'b1, 4'h0, 1'b0);
    wait_rdy();
    $display("test teach done");
    apb(1'b1, cdio_pkg::REG_CTRL, 32'h3);
    w(3);
    ck("healthy error", 0, 32'(healthy));
    u_plc.clear_err();
    w(3);
    ck("healthy clear", 1, 32'(healthy));
    u_plc.drive(1'b0, 4'h0, 1'b0);
    w(3);
    ck("keypad free", 0, 32'(keypad_locked));
    $display("test error done");
    test_done();
  end
endmodule : testbench
